//--- rtl/i2cs_defs.svh
// Register offsets, field positions, reset values and counts of the bus status block
`ifndef I2CS_DEFS_SVH
`define I2CS_DEFS_SVH

// ****************************************************************
// Register byte offsets on the Wishbone slave
// ****************************************************************
`define I2CS_OFF_STATUS 8'h00
`define I2CS_OFF_DATA   8'h04
`define I2CS_OFF_CTRL   8'h08
`define I2CS_OFF_OWN    8'h0C
`define I2CS_OFF_MASK   8'h10

// ****************************************************************
// Status register bit positions
// ****************************************************************
`define I2CS_BIT_DONE 7
`define I2CS_BIT_ADDR 6
`define I2CS_BIT_BUSY 5
`define I2CS_BIT_ARB  4
`define I2CS_BIT_RSV  3
`define I2CS_BIT_DIR  2
`define I2CS_BIT_IRQ  1
`define I2CS_BIT_NACK 0

// ****************************************************************
// Control register bit positions
// ****************************************************************
`define I2CS_CTRL_TX  4
`define I2CS_CTRL_GCE 0

// ****************************************************************
// Reset values and bit counts
// ****************************************************************
`define I2CS_CTRL_RST 8'h00
`define I2CS_MASK_RST 8'h00
`define I2CS_OWN_RST  7'h00
`define I2CS_GC_ADDR  7'h00
`define I2CS_CNT_ADDR 4'h8
`define I2CS_CNT_ACK  4'h9

`endif

//--- rtl/i2cs_pkg.sv
// Types shared by the bus status block
`default_nettype none

package i2cs_pkg;

	// Bus conditions seen on the synchronised pins
	typedef struct packed {
		logic start;
		logic stop;
		logic scl_rise;
		logic scl_fall;
		logic sda;
	} i2cs_bus_ev_t;

	// Frame tracking, Gray coded along idle, address, data
	typedef enum logic [1:0] {
		I2CS_IDLE = 2'b00,
		I2CS_ADDR = 2'b01,
		I2CS_DATA = 2'b11
	} i2cs_state_t;

	// Register access decoded from one Wishbone cycle
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [5:0] word;
		logic [7:0] dat;
	} i2cs_wb_req_t;

endpackage

`default_nettype wire

//--- rtl/i2cs_sync.sv
// Two flip-flop synchroniser for the bus pins
`default_nettype none

module i2cs_sync
	import i2cs_pkg::*;
#(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         resetn,
	// Raw and synchronised levels
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	// ****************************************************************
	// One pair of flops per bit
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic meta_reg; // Read only by the second flop
			// Idle bus is high, so reset to one avoids a false start
			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					meta_reg <= 1'b1;
					dout[g]  <= 1'b1;
				end else begin
					meta_reg <= din[g];
					dout[g]  <= meta_reg;
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

//--- rtl/i2cs_cond_det.sv
// Start, stop and clock edge detector on synchronised pins
`default_nettype none

module i2cs_cond_det
	import i2cs_pkg::*;
(
	// Clock and reset
	input  wire logic   mclk,
	input  wire logic   resetn,
	// Synchronised pins
	input  wire logic   scl_s,
	input  wire logic   sda_s,
	// Detected conditions
	output i2cs_bus_ev_t ev
);

	logic         scl_prev_reg; // Clock level one cycle back
	logic         sda_prev_reg; // Data level one cycle back
	i2cs_bus_ev_t ev_next;      // Conditions before the output flop

	// Data edges while the clock stays high are start and stop
	assign ev_next.start    = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
	assign ev_next.stop     = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
	assign ev_next.scl_rise = scl_s & ~scl_prev_reg;
	assign ev_next.scl_fall = ~scl_s & scl_prev_reg;
	assign ev_next.sda      = sda_s;

	// ****************************************************************
	// History and registered outputs
	// ****************************************************************
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			ev           <= '{default: 1'b0, sda: 1'b1};
		end else begin
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
			ev           <= ev_next;
		end
	end

endmodule

`default_nettype wire

//--- rtl/i2cs_status.sv
// Status flags of the two-wire bus controller with Wishbone registers
`include "i2cs_defs.svh"
`default_nettype none

// What this block does
// - Byte finished sets transfer done, bit 7
// - Data read receiving, write transmitting clears done
// - Done flag meaningful only around a transfer
// - Own address or enabled general call sets addressed
// - Any control register write clears addressed
// - Start sets busy, stop clears busy
// - Lost arbitration sets bit 4, one clears
// - Direction bit holds received read/write bit
// - Done, address match, arbitration loss set pending
// - Ack bit zero if acknowledged, else one
module i2cs_status
	import i2cs_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        resetn,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Two-wire bus pins, sampled only
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	// From the controller's master engine
	input  wire logic        master_mode,
	input  wire logic        sda_release,
	// To the rest of the controller
	output logic      [7:0]  tx_data,
	output logic             tx_mode,
	output logic             general_call_enable,
	output logic             irq
);

	// ****************************************************************
	// Pin synchronisation and condition detection
	// ****************************************************************
	logic [1:0]   pins_s;   // Synchronised {scl, sda}
	i2cs_bus_ev_t ev;       // Conditions on the bus

	i2cs_sync #(.W(2)) u_sync (
		.mclk   (mclk),
		.resetn (resetn),
		.din    ({scl_i, sda_i}),
		.dout   (pins_s)
	);

	i2cs_cond_det u_det (
		.mclk   (mclk),
		.resetn (resetn),
		.scl_s  (pins_s[1]),
		.sda_s  (pins_s[0]),
		.ev     (ev)
	);

	// ****************************************************************
	// Register state
	// ****************************************************************
	i2cs_state_t state_reg;      // Frame position
	i2cs_state_t state_next;
	logic [3:0]  bit_cnt_reg;    // Clock rises seen in this byte
	logic [7:0]  shift_reg;      // Bits received, msb first
	logic [7:0]  rx_data_reg;    // Last full byte from the bus
	logic [7:0]  ctrl_reg;       // Control register
	logic [6:0]  own_addr_reg;   // Own slave address
	logic [7:0]  mask_reg;       // Interrupt mask, status layout
	logic        done_reg;       // Transfer done flag
	logic        addr_reg;       // Addressed as slave flag
	logic        busy_reg;       // Bus busy flag
	logic        arb_reg;        // Arbitration lost flag
	logic        dir_reg;        // Slave direction flag
	logic        irq_pend_reg;   // Interrupt pending flag
	logic        nack_reg;       // Acknowledge received flag, high on none
	logic        ack_reg;        // Wishbone acknowledge
	logic [7:0]  rdata_reg;      // Read data held for the answer

	// ****************************************************************
	// Address matching, used for the address byte and the checks
	// ****************************************************************
	function automatic logic addr_hit(input logic [6:0] rx, input logic [6:0] own,
		input logic gce);
		addr_hit = (rx == own) | (gce & (rx == `I2CS_GC_ADDR));
	endfunction

	// ****************************************************************
	// Bus events
	// ****************************************************************
	wire in_frame   = (state_reg != I2CS_IDLE);
	wire bit_sample = in_frame & ev.scl_rise & (bit_cnt_reg < `I2CS_CNT_ADDR);
	wire ack_evt    = in_frame & ev.scl_rise & (bit_cnt_reg == `I2CS_CNT_ADDR);
	wire addr_done  = (state_reg == I2CS_ADDR) & ev.scl_fall
		& (bit_cnt_reg == `I2CS_CNT_ADDR);
	wire addr_evt   = addr_done & addr_hit(shift_reg[7:1], own_addr_reg,
		ctrl_reg[`I2CS_CTRL_GCE]);
	wire done_evt   = in_frame & ev.scl_fall & (bit_cnt_reg == `I2CS_CNT_ACK);
	// Released line read back low on a clock rise means another master won
	wire arb_evt    = master_mode & in_frame & ev.scl_rise & sda_release & ~ev.sda;

	// ****************************************************************
	// Wishbone decode
	// ****************************************************************
	i2cs_wb_req_t req;
	wire          wb_req   = wb_cyc_i & wb_stb_i;
	wire          wb_fire  = wb_req & ack_reg;
	wire [7:0]    adr_word = {req.word, 2'b00};
	assign req.rd   = wb_fire & ~wb_we_i;
	assign req.wr   = wb_fire & wb_we_i & wb_sel_i[0];
	assign req.word = wb_adr_i[7:2];
	assign req.dat  = wb_dat_i[7:0];

	wire sel_status = (adr_word == `I2CS_OFF_STATUS);
	wire sel_data   = (adr_word == `I2CS_OFF_DATA);
	wire sel_ctrl   = (adr_word == `I2CS_OFF_CTRL);
	wire sel_own    = (adr_word == `I2CS_OFF_OWN);
	wire sel_mask   = (adr_word == `I2CS_OFF_MASK);

	wire wr_status = req.wr & sel_status;
	wire wr_data   = req.wr & sel_data;
	wire wr_ctrl   = req.wr & sel_ctrl;
	wire wr_own    = req.wr & sel_own;
	wire wr_mask   = req.wr & sel_mask;
	wire rd_data   = req.rd & sel_data;

	// Done clears on a data read when receiving, a data write when sending
	wire done_clr = (rd_data & ~tx_mode) | (wr_data & tx_mode);
	// Only a written one clears; a zero leaves the flag alone
	wire arb_clr  = wr_status & req.dat[`I2CS_BIT_ARB];
	wire irq_clr  = wr_status & req.dat[`I2CS_BIT_IRQ];
	wire irq_set  = done_evt | addr_evt | arb_evt;

	// ****************************************************************
	// Status byte and read mux
	// ****************************************************************
	logic [7:0] status_byte;
	always_comb begin
		status_byte                 = 8'h00;
		status_byte[`I2CS_BIT_DONE] = done_reg;
		status_byte[`I2CS_BIT_ADDR] = addr_reg;
		status_byte[`I2CS_BIT_BUSY] = busy_reg;
		status_byte[`I2CS_BIT_ARB]  = arb_reg;
		status_byte[`I2CS_BIT_RSV]  = 1'b0;
		status_byte[`I2CS_BIT_DIR]  = dir_reg;
		status_byte[`I2CS_BIT_IRQ]  = irq_pend_reg;
		status_byte[`I2CS_BIT_NACK] = nack_reg;
	end

	// Unmapped offsets read zero
	wire [7:0] rmux = sel_status ? status_byte :
		sel_data ? rx_data_reg :
		sel_ctrl ? ctrl_reg :
		sel_own  ? {1'b0, own_addr_reg} :
		sel_mask ? mask_reg : 8'h00;

	assign wb_dat_o            = {24'h000000, rdata_reg};
	assign wb_ack_o            = ack_reg;
	assign tx_mode             = ctrl_reg[`I2CS_CTRL_TX];
	assign general_call_enable = ctrl_reg[`I2CS_CTRL_GCE];
	// Level interrupt while any unmasked status bit is set
	assign irq                 = |(status_byte & mask_reg);

	// ****************************************************************
	// Frame state: start opens address phase, stop closes the frame
	// ****************************************************************
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			I2CS_IDLE: begin
				if (ev.start) begin
					state_next = I2CS_ADDR;
				end
			end
			I2CS_ADDR: begin
				if (ev.stop) begin
					state_next = I2CS_IDLE;
				end else if (ev.start) begin
					state_next = I2CS_ADDR;
				end else if (done_evt) begin
					state_next = I2CS_DATA;
				end
			end
			I2CS_DATA: begin
				if (ev.stop) begin
					state_next = I2CS_IDLE;
				end else if (ev.start) begin
					state_next = I2CS_ADDR; // Repeated start
				end
			end
			default: begin
				state_next = I2CS_IDLE;
			end
		endcase
	end

	// Frame position and bit counter
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_reg   <= I2CS_IDLE;
			bit_cnt_reg <= 4'h0;
		end else begin
			state_reg <= state_next;
			if (ev.start | ev.stop | done_evt) begin
				bit_cnt_reg <= 4'h0;
			end else if (in_frame & ev.scl_rise) begin
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
		end
	end

	// Shift in data bits; capture the byte when it ends
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			shift_reg   <= 8'h00;
			rx_data_reg <= 8'h00;
		end else begin
			if (bit_sample) begin
				shift_reg <= {shift_reg[6:0], ev.sda};
			end
			if (done_evt) begin
				rx_data_reg <= shift_reg;
			end
		end
	end

	// ****************************************************************
	// Flags; where set and clear meet, the set wins
	// ****************************************************************
	// Done stays set after the byte until software touches data; its value
	// between frames is left over and means nothing on its own
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			done_reg     <= 1'b0;
			addr_reg     <= 1'b0;
			busy_reg     <= 1'b0;
			arb_reg      <= 1'b0;
			dir_reg      <= 1'b0;
			irq_pend_reg <= 1'b0;
			nack_reg     <= 1'b0;
		end else begin
			done_reg     <= done_evt | (done_reg & ~done_clr);
			addr_reg     <= addr_evt | (addr_reg & ~wr_ctrl);
			busy_reg     <= ev.start | (busy_reg & ~ev.stop);
			arb_reg      <= arb_evt | (arb_reg & ~arb_clr);
			irq_pend_reg <= irq_set | (irq_pend_reg & ~irq_clr);
			if (addr_evt) begin
				dir_reg <= shift_reg[0];
			end
			if (ack_evt) begin
				nack_reg <= ev.sda;
			end
		end
	end

	// ****************************************************************
	// Software registers and Wishbone answer, one wait cycle
	// ****************************************************************
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg     <= `I2CS_CTRL_RST;
			own_addr_reg <= `I2CS_OWN_RST;
			mask_reg     <= `I2CS_MASK_RST;
			tx_data      <= 8'h00;
			ack_reg      <= 1'b0;
			rdata_reg    <= 8'h00;
		end else begin
			ack_reg <= wb_req & ~ack_reg;
			if (wb_req & ~ack_reg) begin
				rdata_reg <= rmux;
			end
			if (wr_ctrl) begin
				ctrl_reg <= req.dat;
			end
			if (wr_own) begin
				own_addr_reg <= req.dat[6:0];
			end
			if (wr_mask) begin
				mask_reg <= req.dat & 8'hF7; // Reserved bit 3 stays zero
			end
			if (wr_data) begin
				tx_data <= req.dat;
			end
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	chk_done_set: assert property (done_evt |=> done_reg ##1 (done_reg | $past(done_clr)))
		else $error("done flag not set after byte");
	chk_done_clr: assert property (done_clr && !done_evt |=> !done_reg)
		else $error("done flag not cleared by data access");
	chk_addr_set: assert property (
		addr_done && addr_hit(shift_reg[7:1], own_addr_reg, general_call_enable)
		|=> addr_reg && status_byte[`I2CS_BIT_IRQ])
		else $error("addressed flag missed a match");
	chk_addr_clr: assert property (wr_ctrl && !addr_evt |=> !addr_reg)
		else $error("control write left addressed flag");
	chk_busy_track: assert property ((ev.start |=> busy_reg) and (ev.stop |=> !busy_reg))
		else $error("busy flag does not follow start and stop");
	chk_arb_sticky: assert property (arb_reg && !arb_clr && !arb_evt |=> $stable(arb_reg))
		else $error("arbitration flag changed without a written one");
	chk_dir_capture: assert property (addr_evt |=> dir_reg == $past(shift_reg[0]))
		else $error("direction flag not taken from address byte");
	chk_irq_sources: assert property (irq_set |=> irq_pend_reg)
		else $error("pending flag not set by event");
	chk_irq_hold: assert property (irq_pend_reg && !irq_clr |=> irq_pend_reg)
		else $error("pending flag lost without a written one");
	chk_ack_sample: assert property (ack_evt |=> nack_reg == $past(ev.sda))
		else $error("acknowledge flag not sampled on ninth clock");
	chk_rsv_zero: assert property (!status_byte[`I2CS_BIT_RSV] && !mask_reg[`I2CS_BIT_RSV])
		else $error("reserved status bit not zero");
	chk_wb_answer: assert property (wb_req && !ack_reg |=> ack_reg ##1 !ack_reg)
		else $error("bus answer not a single cycle");

	cov_addressed: cover property (addr_evt ##[1:400] done_evt);
	cov_arb_lost:  cover property (arb_evt ##[1:400] arb_clr);
	cov_done_read: cover property (done_reg ##[1:400] rd_data);
	cov_restart:   cover property (state_reg == I2CS_DATA && ev.start);

endmodule

`default_nettype wire

//--- tb/i2cs_bus_model.sv
// Model of the other masters and slaves on the two-wire bus
`default_nettype none

module i2cs_bus_model (
	// ****************************************************************
	// Bus lines, a released line reads high through the pull-up
	// ****************************************************************
	output var logic scl,
	output var logic sda
);
	timeunit 1ns;
	timeprecision 1ps;

	// Quarter of the 200 ns link clock period
	localparam int Q = 50;

	// Both lines idle high; the link clock stands still outside frames
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end

	// Start condition: data falls while the clock is high, also as repeated start
	task automatic start();
		sda = 1'b1;
		#(Q) scl = 1'b1;
		#(Q) sda = 1'b0;
		#(Q) scl = 1'b0;
	endtask

	// One clock pulse carrying one bit, data changes only while the clock is low
	task automatic pulse(input logic b);
		scl = 1'b0;
		#(Q) sda = b;
		#(Q) scl = 1'b1;
		#(2*Q) scl = 1'b0;
	endtask

	// Byte msb first, then the ack slot; the acknowledging party pulls low
	task automatic put(input logic [7:0] b, input logic ack);
		for (int i = 7; i >= 0; i--) begin
			pulse(b[i]);
		end
		pulse(~ack);
		// Ack holder lets go, so the pull-up takes the line back high
		#(Q) sda = 1'b1;
	endtask

	// Stop condition: data rises while the clock is high
	task automatic stop();
		scl = 1'b0;
		#(Q) sda = 1'b0;
		#(Q) scl = 1'b1;
		#(Q) sda = 1'b1;
	endtask
endmodule

`default_nettype wire

//--- tb/i2c_status_flags_bench.sv
// Self-checking bench of the bus status block
`include "i2cs_defs.svh"
`default_nettype none

module i2c_status_flags_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import i2cs_pkg::*;

	// ****************************************************************
	// Signals
	// ****************************************************************
	logic        mclk, resetn, cyc, stb, we, mm, rel;
	logic [7:0]  adr;
	logic [31:0] wdat, rdat, q, rnd;
	logic [3:0]  sel;
	logic        ack, scl, sda, irq, gce, txm;
	logic [7:0]  txd;
	logic [6:0]  own;
	int          failures, checks, cycles;

	// Design and far side
	i2cs_status i2cs_status_inst (
		.mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
		.scl_i(scl), .sda_i(sda), .master_mode(mm), .sda_release(rel), .tx_data(txd),
		.tx_mode(txm), .general_call_enable(gce), .irq(irq)
	);
	i2cs_bus_model i2cs_bus_model_inst (.scl(scl), .sda(sda));

	// 40 MHz clock
	always #12.5 mclk = ~mclk;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Next random value, fixed seed keeps runs repeatable
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Expected status word from flags done, addressed, busy, arb, dir, irq, nack;
	// bit 3 always zero
	function automatic logic [31:0] st(input logic [6:0] f);
		return {24'h0, f[6:3], 1'b0, f[2:0]};
	endfunction

	// Compare and report
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	// Classic cycle: hold everything until ack is sampled, take data at that edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 40);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			failures++;
			print_verdict();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, {24'h0, d}, 4'hF);
	endtask

	task automatic rd(input logic [7:0] a);
		wb(1'b0, a, 32'h0, 4'hF);
	endtask

	// Status read compared on the bits of m only
	task automatic sts(input logic [31:0] e, input logic [31:0] m);
		rd(`I2CS_OFF_STATUS);
		chk("status", e & m, q & m);
	endtask

	// Output pins are looked at once the edge's updates have landed
	task automatic pin(input string n, input logic e, ref logic g);
		@(negedge mclk);
		chk(n, {31'h0, e}, {31'h0, g});
	endtask

	// Byte on the bus, then the sync and detect latency of the pins
	task automatic byte_in(input logic [7:0] b, input logic a);
		i2cs_bus_model_inst.put(b, a);
		repeat (4) @(posedge mclk);
	endtask

	task automatic frame(input logic [7:0] b, input logic a);
		i2cs_bus_model_inst.start();
		byte_in(b, a);
	endtask

	task automatic fin(input string n);
		i2cs_bus_model_inst.stop();
		repeat (4) @(posedge mclk);
		$display("test %s finished", n);
	endtask

	task automatic print_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Hang guard, far above the roughly 1200 cycles the tests take
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		{mclk, resetn, cyc, stb, we, mm, rel, adr, wdat, sel} = '0;
		{failures, checks, cycles} = '0;
		rnd = 32'hCBF9;
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		// Reset state, reserved bit, refused accesses
		sts(32'h0, 32'hFF);
		wr(`I2CS_OFF_STATUS, 8'hFF);
		sts(32'h0, 32'hFF);
		rd(8'h14);
		chk("unmapped", 32'h0, q);
		rnd = lfsr(rnd);
		own = {rnd[6:1], 1'b1};
		wr(`I2CS_OFF_OWN, {1'b0, own});
		wb(1'b1, `I2CS_OFF_OWN, 32'h0, 4'h0);
		rd(`I2CS_OFF_OWN);
		chk("own address", {25'h0, own}, q);
		pin("irq", 1'b0, irq);
		// Busy follows start and stop
		i2cs_bus_model_inst.start();
		repeat (4) @(posedge mclk);
		sts(st(7'b0010000), 32'h20);
		fin("busy");
		sts(32'h0, 32'h20);
		// Own address, master writing, then received bytes
		frame({own, 1'b0}, 1'b1);
		sts(st(7'b0110010), 32'h7F);
		pin("irq", 1'b0, irq);
		wr(`I2CS_OFF_MASK, 8'h02);
		pin("irq", 1'b1, irq);
		wr(`I2CS_OFF_STATUS, 8'h00);
		sts(st(7'b0000010), 32'h02);
		wr(`I2CS_OFF_STATUS, 8'h02);
		sts(32'h0, 32'h02);
		pin("irq", 1'b0, irq);
		for (int k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			byte_in(rnd[7:0], rnd[8]);
			sts(st({6'b111001, ~rnd[8]}), 32'hFF);
			rd(`I2CS_OFF_DATA);
			chk("rx byte", {24'h0, rnd[7:0]}, q);
			sts(32'h0, 32'h80);
		end
		wr(`I2CS_OFF_CTRL, 8'h00);
		sts(32'h0, 32'h40);
		fin("slave receive");
		// General call answered only when enabled
		for (int g = 0; g < 2; g++) begin
			wr(`I2CS_OFF_CTRL, {7'h0, g[0]});
			pin("gc enable", g[0], gce);
			frame(8'h00, 1'b1);
			sts(st({1'b0, g[0], 5'b10000}), 32'h40);
			fin("general call");
		end
		// Master reading, refused acknowledge
		wr(`I2CS_OFF_CTRL, 8'h00);
		frame({own, 1'b1}, 1'b0);
		sts(st(7'b0110101), 32'h65);
		fin("slave transmit");
		// Transmit mode: data read keeps done, data write clears it
		wr(`I2CS_OFF_CTRL, 8'h10);
		pin("tx mode", 1'b1, txm);
		frame({own, 1'b1}, 1'b1);
		rnd = lfsr(rnd);
		byte_in(rnd[7:0], 1'b1);
		rd(`I2CS_OFF_DATA);
		sts(32'h80, 32'h80);
		wr(`I2CS_OFF_DATA, rnd[15:8]);
		@(negedge mclk);
		chk("tx data", {24'h0, rnd[15:8]}, {24'h0, txd});
		sts(32'h0, 32'h80);
		// Repeated start: fresh address phase without a stop, direction retaken
		wr(`I2CS_OFF_CTRL, 8'h10);
		frame({own, 1'b0}, 1'b1);
		sts(st(7'b0110000), 32'h64);
		fin("transmit mode");
		// Arbitration lost while our engine releases a data line held low
		wr(`I2CS_OFF_STATUS, 8'hFF);
		@(posedge mclk);
		mm <= 1'b1;
		rel <= 1'b1;
		frame(8'h00, 1'b1);
		@(posedge mclk);
		mm <= 1'b0;
		rel <= 1'b0;
		// Addressed stays from the restarted frame: only a control write clears it
		sts(st(7'b0111010), 32'h72);
		wr(`I2CS_OFF_MASK, 8'h10);
		pin("irq", 1'b1, irq);
		wr(`I2CS_OFF_STATUS, 8'h00);
		sts(st(7'b0001010), 32'h12);
		wr(`I2CS_OFF_STATUS, 8'h12);
		sts(32'h0, 32'h12);
		pin("irq", 1'b0, irq);
		fin("arbitration");
		print_verdict();
	end
endmodule

`default_nettype wire
